// ===== core/tca_pkg.sv
package tca_pkg;

  // Word index on the register bus (byte address is four times this).
  localparam logic [1:0] ADDR_DATA = 2'h0;
  localparam logic [1:0] ADDR_CTRL = 2'h1;

  // Command word layout: D[5:3] all ones marks a command.
  localparam int CMD_LSB = 3;
  localparam logic [2:0] CMD_CODE = 3'h7;
  localparam int CMD_FLAG_BIT = 0;
  localparam int CMD_SEQ_BIT = 1;

  // Mode word layout: D3 is zero, D[5:4] mode, D2 clock, D6/D1/D0 options.
  localparam int MODE_LSB = 4;
  localparam int MODE_MARK_BIT = 3;
  localparam int EXT_BIT = 2;
  localparam int OPT0_BIT = 0;
  localparam int OPT1_BIT = 1;
  localparam int OPT2_BIT = 6;

  // Status byte bit positions.
  localparam int ST_MEAS_BIT = 7;
  localparam int ST_TRIG_BIT = 6;
  localparam int ST_OUT_BIT = 5;
  localparam int ST_MODE_LSB = 3;
  localparam int ST_EXT_BIT = 2;
  localparam int ST_PEND_BIT = 1;
  localparam int ST_RUN_BIT = 0;

  // Reset and preset values.
  localparam logic [15:0] CNT_ONES = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [7:0] RD_ZERO = 8'h00;

  // PWM counter masks for n = 6, 8, 10 and 12.
  localparam logic [15:0] PWM_MASK_6 = 16'h003F;
  localparam logic [15:0] PWM_MASK_8 = 16'h00FF;
  localparam logic [15:0] PWM_MASK_10 = 16'h03FF;
  localparam logic [15:0] PWM_MASK_12 = 16'h0FFF;

  // Operating modes, in the order of the D[5:4] field.
  typedef enum logic [1:0] {
    MODE_DIV,
    MODE_PWM,
    MODE_PULSE,
    MODE_MEAS
  } tca_mode_t;

endpackage

// ===== core/tca_sync.sv
`timescale 1ns/1ns
`default_nettype none

// Brings asynchronous pins into the clock domain and finds their edges.
module tca_sync #(
  parameter int WIDTH = 2 // Number of pins synchronised.
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [WIDTH-1:0] din, // Raw pin levels.
  output logic [WIDTH-1:0] lvl, // Synchronised levels.
  output logic [WIDTH-1:0] rise, // One-cycle rising edge pulses.
  output logic [WIDTH-1:0] fall // One-cycle falling edge pulses.
);

  ////////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic meta_reg; // First stage, read only by the second stage.
      logic sync_reg; // Second stage, safe to use.
      logic last_reg; // Previous safe level, for edge detection.

      // Three flops: two for metastability, one to remember the old level.
      // They track the pin through reset as well, so the chain already holds
      // the real level when reset lifts and an idle pin shows no false edge.
      always_ff @(posedge clk) begin
        meta_reg <= din[i];
        sync_reg <= meta_reg;
        last_reg <= sync_reg;
      end

      assign lvl[i] = sync_reg;
      // Edges are masked while reset is high, when the chain may still be filling.
      assign rise[i] = sync_reg & ~last_reg & ~rst;
      assign fall[i] = ~sync_reg & last_reg & ~rst;
    end
  endgenerate

endmodule // tca_sync

`default_nettype wire

// ===== core/tca_channel.sv
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module tca_channel (
  input wire logic clk, // System clock, 25 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [1:0] avs_address, // Word index.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [7:0] avs_writedata, // Write data.
  output logic [7:0] avs_readdata, // Read data, registered.
  output logic avs_waitrequest, // Stall, registered.
  input wire logic gate_in, // GATE pin.
  input wire logic external_count_clock, // External count clock pin.
  output logic timer_out // OUT pin, registered.
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, the access takes effect on the second edge.
  logic wait_reg; // Drives waitrequest.
  logic [7:0] rdata_reg; // Drives readdata.
  logic [7:0] rdata_next; // Read data for the pending request.
  wire req = avs_read | avs_write; // Any request present.
  wire acc = req & ~wait_reg; // Edge at which the access completes.
  wire wr_data = acc & avs_write & (avs_address == tca_pkg::ADDR_DATA);
  wire wr_ctrl = acc & avs_write & (avs_address == tca_pkg::ADDR_CTRL);
  wire rd_data = acc & avs_read & (avs_address == tca_pkg::ADDR_DATA);
  wire [7:0] wd = avs_writedata; // Short alias for the write byte.

  // Command and mode decode of the control word.
  wire is_cmd = wr_ctrl & (wd[tca_pkg::CMD_LSB+:3] == tca_pkg::CMD_CODE);
  wire cmd_flag = is_cmd & wd[tca_pkg::CMD_FLAG_BIT];
  wire cmd_seq = is_cmd & wd[tca_pkg::CMD_SEQ_BIT];
  wire cmd_latch = is_cmd & ~wd[tca_pkg::CMD_SEQ_BIT] & ~wd[tca_pkg::CMD_FLAG_BIT];
  wire mode_set = wr_ctrl & ~wd[tca_pkg::MODE_MARK_BIT]; // Words with D3 high set no mode.
  wire tca_pkg::tca_mode_t wd_mode = tca_pkg::tca_mode_t'(wd[tca_pkg::MODE_LSB+:2]);

  ////////////////////////////////////////////////////////////////////////////
  // Channel state.
  tca_pkg::tca_mode_t mode_reg; // Current operating mode.
  logic ext_reg; // External count clock selected.
  logic [2:0] opt_reg; // Mode options {D6, D1, D0}.
  logic [15:0] cr_reg, cr_next; // Initial value or measurement buffer.
  logic [15:0] cnt_reg, cnt_next; // Down counter.
  logic [15:0] latch_reg, latch_next; // Readout latch.
  logic [7:0] wr_lo_reg; // Low byte held until the high byte arrives.
  logic wr_hi_reg, rd_hi_reg; // Byte sequence pointers.
  logic out_reg, out_next; // OUT level.
  logic run_reg, run_next; // Counter armed.
  logic pend_reg, pend_next; // Load waiting for the next count clock.
  logic phase_reg, phase_next; // PWM high phase, or a measurement stored.
  logic strobe_reg, strobe_next; // Pulse strobe needs ending.
  logic meas_reg, meas_next; // Measurement window open.
  logic trig_reg, meas_done_reg; // Status flags.
  logic trig_set, meas_set; // Hardware set requests.

  // Pin synchronisers; bit 0 is GATE, bit 1 the external clock.
  logic [1:0] pin_lvl, pin_rise, pin_fall;
  tca_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .rst(rst),
    .din({external_count_clock, gate_in}),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );
  wire gate_lvl = pin_lvl[0];
  wire gate_rise = pin_rise[0];
  wire gate_fall = pin_fall[0];
  wire tick = ext_reg ? pin_fall[1] : 1'b1;

  // Byte assembly of a new initial value.
  wire load_done = wr_data & wr_hi_reg;
  wire [15:0] new_val = {wd, wr_lo_reg};

  // Selected PWM mask from the period option.
  wire [15:0] pwm_mask = (opt_reg[1:0] == 2'h0) ? tca_pkg::PWM_MASK_6 :
                         (opt_reg[1:0] == 2'h1) ? tca_pkg::PWM_MASK_8 :
                         (opt_reg[1:0] == 2'h2) ? tca_pkg::PWM_MASK_10 :
                         tca_pkg::PWM_MASK_12;
  wire [15:0] wd_mask = (wd[1:0] == 2'h0) ? tca_pkg::PWM_MASK_6 :
                        (wd[1:0] == 2'h1) ? tca_pkg::PWM_MASK_8 :
                        (wd[1:0] == 2'h2) ? tca_pkg::PWM_MASK_10 :
                        tca_pkg::PWM_MASK_12;

  // Option aliases per mode.
  wire opt_pulse = opt_reg[0]; // Divide: pulse output; pulse: hard trigger.
  wire opt_strobe = opt_reg[1]; // Pulse: strobe output.
  wire opt_rev = opt_reg[2]; // Pulse: inverted polarity; meas: single.
  wire start_e = opt_reg[0] ? gate_fall : gate_rise;
  wire end_e = opt_reg[1] ? gate_fall : gate_rise;
  wire same_e = (opt_reg[0] == opt_reg[1]); // An edge both ends and starts.
  wire cnt_zero = (cnt_reg == tca_pkg::CNT_ZERO);
  wire [15:0] cnt_dec = cnt_reg - 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // Counter next state. Terminal count is the count clock seen at zero,
  // so a value N spans N+1 count clocks; this is what makes PWM periods
  // come out at 2^n+1 without a separate adjust.
  always_comb begin
    cnt_next = cnt_reg;
    cr_next = cr_reg;
    out_next = out_reg;
    run_next = run_reg;
    pend_next = pend_reg;
    phase_next = phase_reg;
    strobe_next = strobe_reg;
    meas_next = meas_reg;
    trig_set = 1'b0;
    meas_set = 1'b0;
    if (mode_set) begin
      // Any mode entry but measurement stops the counter, and every mode entry presets the register.
      cr_next = tca_pkg::CNT_ONES;
      run_next = 1'b0;
      pend_next = 1'b0;
      phase_next = 1'b0;
      strobe_next = 1'b0;
      meas_next = 1'b0;
      case (wd_mode)
        tca_pkg::MODE_PWM: begin
          cnt_next = wd_mask;
          out_next = 1'b0;
        end
        tca_pkg::MODE_PULSE: begin
          cnt_next = tca_pkg::CNT_ONES;
          out_next = ~wd[tca_pkg::OPT2_BIT];
        end
        tca_pkg::MODE_MEAS: begin
          cnt_next = tca_pkg::CNT_ONES;
          out_next = 1'b0;
          run_next = 1'b1;
        end
        default: begin
          cnt_next = tca_pkg::CNT_ONES;
          out_next = 1'b0;
        end
      endcase
    end else begin
      case (mode_reg)
        tca_pkg::MODE_DIV, tca_pkg::MODE_PWM: begin
          // A rewrite only changes the register; the counter sees it at zero.
          if (load_done) begin
            cr_next = new_val;
            if (!run_reg) begin
              pend_next = 1'b1;
              run_next = 1'b1;
            end
          end
          if (tick && gate_lvl && run_reg) begin
            if (mode_reg == tca_pkg::MODE_DIV && opt_pulse) begin
              out_next = 1'b0;
            end
            if (pend_reg) begin
              pend_next = 1'b0;
              if (mode_reg == tca_pkg::MODE_PWM) begin
                cnt_next = cr_reg & pwm_mask;
                out_next = 1'b1;
                phase_next = 1'b1;
              end else begin
                cnt_next = cr_reg;
              end
            end else if (cnt_zero) begin
              if (mode_reg == tca_pkg::MODE_PWM) begin
                // High phase spans value+1, low phase the complement+1.
                cnt_next = (phase_reg ? ~cr_reg : cr_reg) & pwm_mask;
                out_next = ~phase_reg;
                phase_next = ~phase_reg;
              end else begin
                cnt_next = cr_reg;
                out_next = opt_pulse ? 1'b1 : ~out_reg;
              end
            end else begin
              cnt_next = cnt_dec;
            end
          end
        end
        tca_pkg::MODE_PULSE: begin
          if (load_done) begin
            cr_next = new_val;
          end
          if (tick && (opt_pulse || gate_lvl)) begin
            if (strobe_reg) begin
              out_next = opt_rev;
              strobe_next = 1'b0;
            end
            if (pend_reg) begin
              cnt_next = cr_reg;
              pend_next = 1'b0;
              out_next = opt_rev;
            end else if (run_reg) begin
              if (cnt_zero) begin
                cnt_next = tca_pkg::CNT_ONES;
                run_next = 1'b0;
                out_next = ~opt_rev;
                strobe_next = opt_strobe;
              end else begin
                cnt_next = cnt_dec;
              end
            end
          end
          // A trigger arms a load on the next count clock, even mid-count.
          if (opt_pulse ? gate_rise : load_done) begin
            trig_set = 1'b1;
            pend_next = 1'b1;
            run_next = 1'b1;
          end
        end
        tca_pkg::MODE_MEAS: begin
          out_next = 1'b0;
          if (run_reg && tick) begin
            cnt_next = cnt_dec;
          end
          if (run_reg && meas_reg && end_e) begin
            cr_next = ~cnt_reg;
            out_next = 1'b1;
            meas_set = 1'b1;
            phase_next = 1'b1;
            if (opt_rev) begin
              cnt_next = cnt_reg;
              run_next = 1'b0;
            end else begin
              cnt_next = tca_pkg::CNT_ONES;
            end
            meas_next = same_e;
          end else if (run_reg && !meas_reg && start_e) begin
            // Only the very first start edge transfers, and silently.
            if (!phase_reg) begin
              cr_next = ~cnt_reg;
            end
            cnt_next = tca_pkg::CNT_ONES;
            meas_next = 1'b1;
          end
        end
        default: begin
          cnt_next = cnt_reg;
        end
      endcase
    end
  end

  // Readout latch: a measuring channel latches its buffer, else the counter.
  always_comb begin
    latch_next = latch_reg;
    if (cmd_latch) begin
      latch_next = (mode_reg == tca_pkg::MODE_MEAS) ? cr_reg : cnt_reg;
    end
  end

  // Read data for the pending request; unmapped words read zero.
  always_comb begin
    rdata_next = tca_pkg::RD_ZERO;
    if (avs_address == tca_pkg::ADDR_DATA) begin
      rdata_next = rd_hi_reg ? latch_reg[15:8] : latch_reg[7:0];
    end else if (avs_address == tca_pkg::ADDR_CTRL) begin
      rdata_next[tca_pkg::ST_MEAS_BIT] = meas_done_reg;
      rdata_next[tca_pkg::ST_TRIG_BIT] = trig_reg;
      rdata_next[tca_pkg::ST_OUT_BIT] = out_reg;
      rdata_next[tca_pkg::ST_MODE_LSB+:2] = mode_reg;
      rdata_next[tca_pkg::ST_EXT_BIT] = ext_reg;
      rdata_next[tca_pkg::ST_PEND_BIT] = pend_reg;
      rdata_next[tca_pkg::ST_RUN_BIT] = run_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_reg <= 1'b1;
      rdata_reg <= tca_pkg::RD_ZERO;
    end else begin
      wait_reg <= ~(req & wait_reg);
      rdata_reg <= (req & wait_reg) ? rdata_next : rdata_reg;
    end
  end

  // Mode and option registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= tca_pkg::MODE_DIV;
      ext_reg <= 1'b0;
      opt_reg <= 3'h0;
    end else if (mode_set) begin
      mode_reg <= wd_mode;
      ext_reg <= wd[tca_pkg::EXT_BIT];
      opt_reg <= {wd[tca_pkg::OPT2_BIT], wd[tca_pkg::OPT1_BIT], wd[tca_pkg::OPT0_BIT]};
    end
  end

  // Byte sequence pointers; a mode word or sequence clear restarts both.
  always_ff @(posedge clk) begin
    if (rst || mode_set || cmd_seq) begin
      wr_hi_reg <= 1'b0;
      rd_hi_reg <= 1'b0;
    end else begin
      wr_hi_reg <= wr_data ? ~wr_hi_reg : wr_hi_reg;
      rd_hi_reg <= cmd_latch ? 1'b0 : (rd_data ? ~rd_hi_reg : rd_hi_reg);
    end
  end

  // Low byte holding register.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_lo_reg <= 8'h00;
    end else if (wr_data && !wr_hi_reg) begin
      wr_lo_reg <= wd;
    end
  end

  // Counter datapath registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      cr_reg <= tca_pkg::CNT_ONES;
      cnt_reg <= tca_pkg::CNT_ONES;
      latch_reg <= tca_pkg::CNT_ONES;
    end else begin
      cr_reg <= cr_next;
      cnt_reg <= cnt_next;
      latch_reg <= latch_next;
    end
  end

  // Control flops of the counter.
  always_ff @(posedge clk) begin
    if (rst) begin
      out_reg <= 1'b0;
      run_reg <= 1'b0;
      pend_reg <= 1'b0;
      phase_reg <= 1'b0;
      strobe_reg <= 1'b0;
      meas_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      run_reg <= run_next;
      pend_reg <= pend_next;
      phase_reg <= phase_next;
      strobe_reg <= strobe_next;
      meas_reg <= meas_next;
    end
  end

  // Status flags: a set in the same cycle as a clear wins.
  always_ff @(posedge clk) begin
    if (rst || mode_set) begin
      trig_reg <= 1'b0;
      meas_done_reg <= 1'b0;
    end else begin
      trig_reg <= trig_set | (trig_reg & ~cmd_flag);
      meas_done_reg <= meas_set | (meas_done_reg & ~cmd_flag);
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign timer_out = out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the channel's own behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_flag_clear_both: assert property (
    (cmd_flag && !trig_set && !meas_set) |=> (!trig_reg && !meas_done_reg))
    else $error("flag clear left a flag set");

  a_seq_clear_cmd: assert property (
    cmd_seq |=> (!wr_hi_reg && !rd_hi_reg))
    else $error("sequence clear did not reset byte pointers");

  a_latch_holds: assert property (
    (cmd_latch && mode_reg != tca_pkg::MODE_MEAS) |=> (latch_reg == $past(cnt_reg)) ##1
    (cmd_latch || latch_reg == $past(latch_reg)))
    else $error("latched count not captured or not held");

  a_div_preset: assert property (
    (mode_set && wd_mode == tca_pkg::MODE_DIV) |=>
    (cnt_reg == tca_pkg::CNT_ONES && cr_reg == tca_pkg::CNT_ONES && !timer_out))
    else $error("divide mode entry preset wrong");

  a_pwm_preset: assert property (
    (mode_set && wd_mode == tca_pkg::MODE_PWM) |=>
    (cnt_reg == pwm_mask && cr_reg == tca_pkg::CNT_ONES && !timer_out))
    else $error("PWM mode entry preset wrong");

  a_pulse_preset: assert property (
    (mode_set && wd_mode == tca_pkg::MODE_PULSE) |=> (cnt_reg == tca_pkg::CNT_ONES && timer_out == !opt_rev))
    else $error("pulse mode entry preset wrong");

  a_div_reload: assert property (
    (!mode_set && mode_reg == tca_pkg::MODE_DIV && tick && gate_lvl && run_reg && !pend_reg
    && cnt_zero) |=> (cnt_reg == $past(cr_reg)))
    else $error("divide counter did not reload at zero");

  a_gate_hold: assert property (
    (!mode_set && (mode_reg == tca_pkg::MODE_DIV || mode_reg == tca_pkg::MODE_PWM) && !gate_lvl)
    |=> $stable(cnt_reg))
    else $error("counter moved while GATE low");

  a_meas_pulse_one: assert property (
    (mode_reg == tca_pkg::MODE_MEAS && !mode_set && timer_out) |=> !timer_out)
    else $error("measurement pulse longer than one clock");

  a_reset_state: assert property (
    $fell(rst) |-> (!run_reg && cnt_reg == tca_pkg::CNT_ONES && latch_reg == tca_pkg::CNT_ONES
    && mode_reg == tca_pkg::MODE_DIV && !timer_out))
    else $error("reset state wrong");

endmodule // tca_channel

`default_nettype wire

// ===== tb/tca_far.sv
`timescale 1ns/1ns
`default_nettype none

// Far-side source of the GATE pin and the external count clock.
module tca_far (
  input wire logic clk, // System clock.
  input wire logic gate_lvl, // GATE level while not toggling.
  input wire logic [7:0] gate_per, // GATE half period, zero holds the level.
  input wire logic [3:0] external_count_clock_half, // Count clock half period, zero stops it.
  output logic gate_in, // GATE pin.
  output logic external_count_clock // External count clock pin.
);
  logic [7:0] gcnt; // Cycles into the GATE half period.
  logic [3:0] xcnt; // Cycles into the count clock half period.

  ////////////////////////////////////////////////////////////////////////////////
  // Both pins start high and settled, so reset sees no edge.
  initial begin
    gcnt = 8'h00;
    xcnt = 4'h0;
    gate_in = 1'b1;
    external_count_clock = 1'b1;
  end

  // GATE follows the level or toggles; half periods far above two clocks keep each level seen.
  always @(posedge clk) begin
    gcnt <= (gcnt + 8'h01 >= gate_per) ? 8'h00 : gcnt + 8'h01;
    if (gate_per == 8'h00) begin
      gate_in <= gate_lvl;
    end else if (gcnt + 8'h01 >= gate_per) begin
      gate_in <= ~gate_in;
    end
  end

  // The count clock idles high between bursts, so no stray falling edge is counted.
  always @(posedge clk) begin
    xcnt <= (xcnt + 4'h1 >= external_count_clock_half) ? 4'h0 : xcnt + 4'h1;
    if (external_count_clock_half == 4'h0) begin
      external_count_clock <= 1'b1;
    end else if (xcnt + 4'h1 >= external_count_clock_half) begin
      external_count_clock <= ~external_count_clock;
    end
  end
endmodule // tca_far

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ns
`default_nettype none

// Self-checking bench for one timer channel.
module tb;
  logic clk = 1'b0; // System clock.
  logic rst = 1'b1; // Synchronous reset.
  logic [1:0] avs_address = 2'h0; // Word index.
  logic avs_read = 1'b0; // Read strobe.
  logic avs_write = 1'b0; // Write strobe.
  logic [7:0] avs_writedata = 8'h00; // Write byte.
  logic [7:0] avs_readdata; // Read byte.
  logic avs_waitrequest; // Bus stall.
  logic gate_in; // GATE pin.
  logic external_count_clock; // Count clock pin.
  logic timer_out; // OUT pin.
  logic gate_lvl = 1'b1; // Static GATE level.
  logic [7:0] gate_per = 8'h00; // GATE toggling half period.
  logic [3:0] external_count_clock_half = 4'h0; // Count clock half period.
  logic [7:0] lf = 8'h5F; // Random state, starts at 95.
  logic [15:0] rd_q[$]; // Expected reads, mask over value.
  logic [15:0] note; // Oldest expected read.
  logic [15:0] v; // Loaded count.
  logic [15:0] n; // Measured interval.
  int mismatches = 0; // Failed comparisons.
  int num_checks = 0; // All comparisons.

  tca_channel DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .gate_in(gate_in),
    .external_count_clock(external_count_clock), .timer_out(timer_out));
  tca_far far (.clk(clk), .gate_lvl(gate_lvl), .gate_per(gate_per), .external_count_clock_half(external_count_clock_half),
    .gate_in(gate_in), .external_count_clock(external_count_clock));

  ////////////////////////////////////////////////////////////////////////////////
  // A 40 ns clock.
  initial begin
    forever #20 clk = ~clk;
  end

  // Eight-bit shift register for random counts.
  function automatic logic [7:0] next_rand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Compares one result, counting and reporting.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds a request until waitrequest is sampled low, then lets an edge pass.
  task automatic bus(input logic is_rd, input logic [1:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= is_rd;
    avs_write <= ~is_rd;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus(1'b0, a, d);
  endtask

  // Notes the expected byte, then reads; the watcher compares.
  task automatic rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    rd_q.push_back({m, e});
    bus(1'b1, a, 8'h00);
  endtask

  // Counts clocks until the output changes; bounded so a stuck output cannot hang.
  task automatic wait_chg(output logic [15:0] cnt);
    logic old;
    old = timer_out;
    cnt = 16'h0000;
    do begin
      @(posedge clk);
      cnt++;
    end while (timer_out === old && cnt < 16'h2000);
    if (cnt >= 16'h2000) mismatches++; // A stuck output is a failure.
  endtask

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Read answers are taken at the edge where waitrequest is low.
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      note = rd_q.pop_front();
      chk({8'h00, avs_readdata & note[15:8]}, {8'h00, note[7:0]});
    end
  end

  // Watchdog well past the several hundred cycles the run needs.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(2'h1, 8'hFF, 8'h00);
    chk({15'h0000, timer_out}, 16'h0000);
    wr(2'h1, 8'h38);
    rd(2'h0, 8'hFF, 8'hFF);
    rd(2'h0, 8'hFF, 8'hFF);
    rd(2'h2, 8'hFF, 8'h00);
    // Divide mode on the system clock, then on the external clock; a stray byte is discarded.
    for (int e = 0; e < 2; e++) begin
      lf = next_rand(lf);
      v = {12'h000, lf[3:0]} + 16'h0002;
      wr(2'h1, e[0] ? 8'h04 : 8'h00);
      @(posedge clk);
      chk({15'h0000, timer_out}, 16'h0000);
      rd(2'h1, 8'h04, {5'h00, e[0], 2'h0});
      wr(2'h0, 8'hA5);
      wr(2'h1, 8'h3A);
      wr(2'h0, v[7:0]);
      external_count_clock_half <= e[0] ? 4'h3 : 4'h0;
      wr(2'h0, v[15:8]);
      wait_chg(n);
      wait_chg(n);
      chk(n, (v + 16'h0001) * (e[0] ? 16'h0006 : 16'h0001));
    end
    // PWM with n of six: high for the count plus one, period of 65.
    external_count_clock_half <= 4'h0;
    lf = next_rand(lf);
    v = {11'h000, lf[4:0]} + 16'h0001;
    wr(2'h1, 8'h10);
    wr(2'h0, v[7:0]);
    wr(2'h0, 8'h00);
    do wait_chg(n); while (timer_out !== 1'b1);
    wait_chg(n);
    chk(n, v + 16'h0001);
    wait_chg(n);
    chk(n, 16'h0040 - v);
    // Soft-triggered one-shot, then flag clear and a latch of the idle counter.
    wr(2'h1, 8'h20);
    @(posedge clk);
    chk({15'h0000, timer_out}, 16'h0001);
    wr(2'h0, 8'h0A);
    wr(2'h0, 8'h00);
    wait_chg(n);
    wait_chg(n);
    chk({15'h0000, timer_out}, 16'h0001);
    rd(2'h1, 8'h40, 8'h40);
    wr(2'h1, 8'h39);
    rd(2'h1, 8'hC0, 8'h00);
    wr(2'h1, 8'h38);
    rd(2'h0, 8'hFF, 8'hFF);
    rd(2'h0, 8'hFF, 8'hFF);
    // Continuous rise-to-rise measurement: no pulse on the first edge, one clock on the next.
    wr(2'h1, 8'h30);
    gate_per <= 8'h14;
    wait_chg(n);
    chk({15'h0000, n > 16'h0040}, 16'h0001);
    wait_chg(n);
    chk(n, 16'h0001);
    rd(2'h1, 8'h98, 8'h98);
    // The buffer holds the complement of the down counter, a short count, so its top bits are zero.
    wr(2'h1, 8'h38);
    rd(2'h0, 8'hC0, 8'h00);
    rd(2'h0, 8'hFF, 8'h00);
    // Hard-triggered inverted strobe: one GATE rise loads at the next count clock.
    gate_per <= 8'h00;
    gate_lvl <= 1'b0;
    wr(2'h1, 8'h63);
    @(posedge clk);
    chk({15'h0000, timer_out}, 16'h0000);
    wr(2'h0, 8'h05);
    wr(2'h0, 8'h00);
    gate_lvl <= 1'b1;
    wait_chg(n);
    wait_chg(n);
    chk(n, 16'h0006);
    wait_chg(n);
    chk(n, 16'h0001);
    rd(2'h1, 8'h40, 8'h40);
    complete_run;
  end
endmodule // tb

`default_nettype wire
